/* logic/bar_reset_ctrl.sv */
// Own bus address and self-clearing software reset registers
`timescale 1ns/100ps
`include "bar_regs.svh"

module bar_reset_ctrl
    import bar_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire bar_reg_req_t   reg_req,
    output logic [7:0]          reg_rdata,
    input  wire logic [6:0]     address_strap_pin,
    output logic [6:0]          own_bus_address_field,
    output logic                address_source_select,
    output logic [6:0]          answer_address,
    output bar_reset_out_t      reset_out
);

    localparam int NRST = 3;

    // Register port: a write takes effect at the edge that samples its strobe;
    // read data is registered, stands from the edge that samples the read strobe and
    // holds until the next read. Reset holds last a fixed number of cycles.

    logic [6:0]      strap_addr_reg;
    logic            strap_done_reg;
    logic [6:0]      addr_field_reg;
    logic            addr_sel_reg;
    logic [NRST-1:0] rst_start;
    logic [NRST-1:0] rst_active;
    logic [NRST-1:0] rst_active_d_reg;
    logic            nvm_armed_reg;
    logic            nvm_pulse_reg;
    logic [7:0]      reg_rdata_reg;
    logic [7:0]      rdata_next;
    logic            wr_addr;
    logic            wr_reset;
    logic            wr_bridge_nvm;
    logic            full_end;
    logic            keep_start;
    logic            full_start;

    // One request carries one offset, so at most one of these is high
    always_comb begin
        wr_addr       = 1'b0;
        wr_reset      = 1'b0;
        wr_bridge_nvm = 1'b0;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `BAR_OFF_OWN_ADDR: begin
                    wr_addr = 1'b1;
                end
                `BAR_OFF_SOFT_RESET: begin
                    wr_reset = 1'b1;
                end
                // Only the restore bit of the bridge control register is watched here
                `BAR_OFF_BRIDGE_CONTROL_REG: begin
                    wr_bridge_nvm = reg_req.wdata[`BAR_BRIDGE_NVM_BIT];
                end
                default: begin
                    wr_addr = 1'b0;
                end
            endcase
        end
    end

    // Index 0 keeps registers, 1 resets all, 2 resets the video input
    assign rst_start[0] = wr_reset && reg_req.wdata[`BAR_RST_KEEP_BIT];   // see R7
    assign rst_start[1] = wr_reset && reg_req.wdata[`BAR_RST_FULL_BIT];   // see R4
    assign rst_start[2] = wr_reset && reg_req.wdata[`BAR_RST_VIDEO_BIT];  // see R3
    assign keep_start   = rst_start[0];
    assign full_start   = rst_start[1];

    // Each reset has its own hold, so several bits in one write start together
    genvar gi;
    generate
        for (gi = 0; gi < NRST; gi++) begin : g_hold
            bar_pulse_hold u_hold (
                .clk    (clk),
                .rst    (rst),
                .start  (rst_start[gi]),
                .active (rst_active[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_active_d_reg <= '0;
        end else begin
            rst_active_d_reg <= rst_active;
        end
    end

    // The end of the full hold arms the restore path; the hold counters are not
    // cleared by the reset that they themselves drive
    assign full_end = rst_active_d_reg[1] && !rst_active[1];

    // Done flag is set on the first edge after release; the strap is never taken
    // under the async reset, where the pins may still be settling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    // A full reset takes the strap again, as a power-up would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_addr_reg <= '0;
        end else if (!strap_done_reg || full_start) begin
            strap_addr_reg <= address_strap_pin;                          // see R1
        end
    end

    // Address field takes the strap once after release, then holds it until software or a reset reloads it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_field_reg <= '0;
        end else if (!strap_done_reg) begin
            addr_field_reg <= address_strap_pin;                          // see R1
        end else if (full_start) begin
            addr_field_reg <= address_strap_pin;                          // see R4
        end else if (keep_start) begin
            addr_field_reg <= strap_addr_reg;                             // see R8
        end else if (wr_addr) begin
            addr_field_reg <= reg_req.wdata[`BAR_ADDR_FIELD_HI:`BAR_ADDR_FIELD_LO];
        end
    end

    // The select has a fixed default, not a strap one, so the register-keeping
    // reset leaves a software choice of address source in place
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_sel_reg <= `BAR_ADDR_SEL_RESET;
        end else if (full_start) begin
            addr_sel_reg <= `BAR_ADDR_SEL_RESET;                          // see R4
        end else if (wr_addr && strap_done_reg) begin
            addr_sel_reg <= reg_req.wdata[`BAR_ADDR_SEL_BIT];             // see R2
        end
    end

    assign own_bus_address_field = addr_field_reg;
    assign address_source_select = addr_sel_reg;
    assign answer_address        = addr_sel_reg ? addr_field_reg : strap_addr_reg; // see R2

    // Armed by the end of a full reset; a bridge bit write consumes it.
    // Arming wins over a consuming write in the same cycle, so a restore
    // request that meets the end of a second full reset is not lost.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nvm_armed_reg <= 1'b0;
        end else if (full_end) begin
            nvm_armed_reg <= 1'b1;
        end else if (wr_bridge_nvm) begin
            nvm_armed_reg <= 1'b0;
        end
    end

    // One-cycle restore pulse; a bridge write with no full reset behind it does nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nvm_pulse_reg <= 1'b0;
        end else begin
            nvm_pulse_reg <= wr_bridge_nvm && nvm_armed_reg;              // see R6
        end
    end

    assign reset_out.video_in_reset         = rst_active[2];              // see R3
    assign reset_out.full_logic_reset       = rst_active[1];              // see R4
    assign reset_out.logic_reset_keep_regs  = rst_active[0];              // see R7
    assign reset_out.restore_fixed_defaults = rst_active[0];              // see R9
    assign reset_out.restore_nvm_defaults   = nvm_pulse_reg;              // see R6

    // Self-clearing bits read 1 only while their hold runs; reserved bits read 0
    always_comb begin
        rdata_next = `BAR_DATA_ZERO;                                      // see R11
        case (reg_req.addr)
            `BAR_OFF_OWN_ADDR: begin
                rdata_next[`BAR_ADDR_FIELD_HI:`BAR_ADDR_FIELD_LO] = addr_field_reg;
                rdata_next[`BAR_ADDR_SEL_BIT] = addr_sel_reg;
            end
            `BAR_OFF_SOFT_RESET: begin
                rdata_next[`BAR_RST_VIDEO_BIT] = rst_active[2];           // see R12
                rdata_next[`BAR_RST_FULL_BIT]  = rst_active[1];           // see R12
                rdata_next[`BAR_RST_KEEP_BIT]  = rst_active[0];           // see R12
            end
            // Unmapped offsets, the watched bridge control included, read as zero
            default: begin
                rdata_next = `BAR_DATA_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= `BAR_DATA_ZERO;
        end else if (reg_req.rd) begin
            reg_rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = reg_rdata_reg;

endmodule : bar_reset_ctrl

/* pkg/bar_regs.svh */
// Register offsets, field positions, reset values and timing counts for the reset control block
// Behaviour
// R1 - Bits 7:1 of the address register hold the device's own 7-bit bus address, loaded from the strap at reset.
// R2 - Bit 0 of the address register picks the answering address: 0 the strap address, 1 the stored field.
// R3 - Writing 1 to reset bit 4 resets the video-input block, and the bit then clears itself.
// R4 - Writing 1 to reset bit 1 resets all digital logic and all registers, and the bit then clears itself.
// R5 - After a full reset the host sets bit 1 of the bridge control register to bring back memory-loaded defaults.
// R6 - Setting bridge control bit 1 after a full reset restores the memory-loaded registers to their defaults.
// R7 - Writing 1 to reset bit 0 resets all digital logic except the registers, and the bit then clears itself.
// R8 - The register-keeping reset reloads every strap-loaded register with its sampled strap value.
// R9 - The register-keeping reset also returns a fixed list of registers, 0x48 to 0x55, 0xC0 and 0x015, to default.
// R10 - The host issues reset-register writes only while the bus runs in its 3.3V signalling mode.
// R11 - Reset register bits 7:5 and 3:2 are reserved and read as zero.
// R12 - Each self-clearing reset bit reads 1 while its reset runs and 0 once it is done.
`ifndef BAR_REGS_SVH
`define BAR_REGS_SVH

`define BAR_OFF_OWN_ADDR      8'h00
`define BAR_OFF_SOFT_RESET    8'h01
`define BAR_OFF_BRIDGE_CONTROL_REG    8'h4f

`define BAR_ADDR_FIELD_HI     7
`define BAR_ADDR_FIELD_LO     1
`define BAR_ADDR_SEL_BIT      0
`define BAR_ADDR_SEL_RESET    1'b0

`define BAR_RST_VIDEO_BIT     4
`define BAR_RST_FULL_BIT      1
`define BAR_RST_KEEP_BIT      0
`define BAR_RST_BITS_USED     3'h3
`define BAR_SOFT_RESET_RESET  8'h00
`define BAR_BRIDGE_NVM_BIT    1

`define BAR_DATA_ZERO         8'h00

`define BAR_CLK_NS            40
`define BAR_RST_HOLD_NS       200
`define BAR_RST_HOLD_CYC      ((`BAR_RST_HOLD_NS + `BAR_CLK_NS - 1) / `BAR_CLK_NS)
`define BAR_CNT_W             4

`endif

/* pkg/bar_pkg.sv */
// Types shared by the reset control block
package bar_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bar_reg_req_t;

    typedef struct packed {
        logic video_in_reset;
        logic full_logic_reset;
        logic logic_reset_keep_regs;
        logic restore_fixed_defaults;
        logic restore_nvm_defaults;
    } bar_reset_out_t;

endpackage : bar_pkg

/* logic/bar_pulse_hold.sv */
// Holds a reset request active for a fixed number of clock cycles
`timescale 1ns/100ps
`include "bar_regs.svh"

module bar_pulse_hold
    import bar_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      active
);

    logic [`BAR_CNT_W-1:0] cnt_reg;

    // A new start while running restarts the hold, so a repeated write never shortens it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (start) begin
            cnt_reg <= `BAR_CNT_W'(`BAR_RST_HOLD_CYC);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - `BAR_CNT_W'(1);
        end
    end

    assign active = (cnt_reg != '0);

endmodule : bar_pulse_hold

/* verif/bar_host_model.sv */
// Host model driving the register strobe port
`timescale 1ns/100ps
module bar_host_model
    import bar_pkg::*;
(
    input  wire logic [7:0] rdata,
    input  wire logic       clk,
    output bar_reg_req_t    req
);
    initial req = '0;
    // Soft resets are only issued in 3.3V bus signalling mode
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk) #1;
        req = {w, ~w, a, d};
        @(posedge clk) #1;
        q = rdata;
        // Released lines get the inverse so stale values never look valid
        req = {2'b00, ~a, ~d};
    endtask : xfer
endmodule : bar_host_model

/* verif/bar_reset_ctrl_checker.sv */
// Concurrent checks on the address and soft reset ports
`timescale 1ns/100ps
module bar_checker
    import bar_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst,
    input wire bar_reg_req_t   reg_req,
    input wire logic [7:0]     reg_rdata,
    input wire logic [6:0]     own_bus_address_field,
    input wire logic           address_source_select,
    input wire logic [6:0]     answer_address,
    input wire bar_reset_out_t reset_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire w1 = reg_req.wr && reg_req.addr == 8'h01;
    wire w4 = reg_req.wr && reg_req.addr == 8'h4f && reg_req.wdata[1];
    wire kp = reset_out.logic_reset_keep_regs;
    wire nv = reset_out.restore_nvm_defaults;
    property p_video; w1 && reg_req.wdata[4] |=> reset_out.video_in_reset [*5]; endproperty
    a_video: assert property (p_video) else $error("video reset hold");
    property p_full; w1 && reg_req.wdata[1] |=> reset_out.full_logic_reset [*5]; endproperty
    a_full: assert property (p_full) else $error("full reset hold");
    property p_keep; w1 && reg_req.wdata[0] |=> kp [*5]; endproperty
    a_keep: assert property (p_keep) else $error("keep reset hold");
    property p_fixed;
        w1 && reg_req.wdata[0] |=> reset_out.restore_fixed_defaults [*5];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed defaults");
    property p_sel; address_source_select |-> answer_address == own_bus_address_field; endproperty
    a_sel: assert property (p_sel) else $error("answer address");
    property p_addr;
        reg_req.wr && reg_req.addr == 8'h00 |=>
            {own_bus_address_field, address_source_select} == $past(reg_req.wdata);
    endproperty
    a_addr: assert property (p_addr) else $error("address write");
    property p_resv;
        reg_req.rd && reg_req.addr == 8'h01 |=>
            reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0 && reg_rdata[0] == $past(kp);
    endproperty
    a_resv: assert property (p_resv) else $error("reset readback");
    property p_nvm; nv |-> $past(w4) ##1 !nv; endproperty
    a_nvm: assert property (p_nvm) else $error("restore pulse");
    c_keep: cover property (w1 && reg_req.wdata[0]);
    c_full: cover property ($fell(reset_out.full_logic_reset));
    c_nvm: cover property (nv);
endmodule : bar_checker

/* verif/test_bus_address_and_reset_control.sv */
// Self-checking bench for the address and soft reset registers
`timescale 1ns/100ps
module test_bus_address_and_reset_control import bar_pkg::*;;
    logic           clk = 0;
    logic           rst = 1;
    logic [6:0]     strap = 7'h3a;
    bar_reg_req_t   req;
    logic [7:0]     rdata;
    logic [7:0]     q;
    logic [6:0]     field;
    logic [6:0]     ans;
    logic           sel;
    bar_reset_out_t ro;
    int             err_count = 0;
    int             n_compared = 0;
    int             cyc = 0;
    initial forever #20 clk = ~clk;
    bar_reset_ctrl dut_u (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
        .address_strap_pin(strap), .own_bus_address_field(field),
        .address_source_select(sel), .answer_address(ans), .reset_out(ro));
    bar_host_model hu (.rdata(rdata), .clk(clk), .req(req));
    task automatic chk(input string n, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        hu.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, e);
        hu.xfer(1'b0, a, 8'h00, q);
        chk(n, q, e);
    endtask : rd
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 0;
        repeat (2) @(posedge clk);
        rd("addr_reg", 8'h00, 8'h74);
        chk("answer", ans, 8'h3a);
        rd("reset_reg", 8'h01, 8'h00);
        rd("unmapped", 8'h4f, 8'h00);
        wr(8'h00, 8'h2b);
        chk("answer", ans, 8'h15);
        strap = 7'h2c;
        wr(8'h01, 8'hf1);
        chk("video_keep", ro.video_in_reset & ro.logic_reset_keep_regs, 8'h01);
        chk("fixed", ro.restore_fixed_defaults, 8'h01);
        rd("reset_reg", 8'h01, 8'h11);
        repeat (6) @(posedge clk);
        rd("reset_reg", 8'h01, 8'h00);
        chk("video_idle", ro.video_in_reset, 8'h00);
        chk("keep_idle", ro.logic_reset_keep_regs | ro.restore_fixed_defaults, 8'h00);
        chk("field", field, 8'h3a);
        wr(8'h4f, 8'h02);
        chk("nvm", ro.restore_nvm_defaults, 8'h00);
        wr(8'h01, 8'h02);
        chk("full", ro.full_logic_reset, 8'h01);
        repeat (6) @(posedge clk);
        #1;
        chk("full_idle", ro.full_logic_reset, 8'h00);
        chk("sel", sel, 8'h00);
        chk("field", field, 8'h2c);
        chk("answer", ans, 8'h2c);
        wr(8'h4f, 8'h02);
        chk("nvm", ro.restore_nvm_defaults, 8'h01);
        repeat (3) @(posedge clk);
        tally_and_finish;
    end
endmodule : test_bus_address_and_reset_control
bind bar_reset_ctrl bar_checker chk_u (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .own_bus_address_field(own_bus_address_field),
    .address_source_select(address_source_select), .answer_address(answer_address),
    .reset_out(reset_out));
